// >>> design/qpc_counter.sv
// quadrature position counter: filters, x2/x4 decode, 16-bit position count, timer mode
// assumes encoder pins synchronous to clock and a one-cycle register read/write port
//
// Operation
// - error checking only in the index-reset modes 100 and 110
// - count hitting all-ones down or max plus one up sets error flag, raises interrupt
// - error interrupt suppressed by disable bit; flag still set
// - after an error keep counting; no interrupt on the natural rollover
// - error flag software readable and writable; hardware never clears it
// - index reset of the count only when index reset enable is 1
// - index reset only when phase levels match the index match value
// - x4: match bit 1 is phase B level, bit 0 phase A level
// - x2: match bit 1 picks phase (0 A, 1 B), bit 0 its level
// - index reset disabled: interrupt on index and still on count error
// - direction drives an output pin and a read-only status bit
// - x2 modes count on both edges of phase A; phase B gives direction
// - x4 modes count on every edge of both phases
// - codes 100/110 reset on index, 101/111 reset on max count match
// - filter output changes after three stable filter clock samples
// - filter clock divided from the instruction clock by a three-bit field
// - filtered inputs used only when enabled; filters off after reset
// - mode 001 is a 16-bit timer on phase A with max as period
// - timer direction from phase B pin or software direction bit
// - mode switching keeps the count; timer clock synchronous to clock
// - sleep halts all counting
// - idle halts only when idle stop is set; idle stop resets to 0
// - phase A leading phase B counts up, lagging counts down
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "qpc_regs.svh"

module qpc_counter (
  input wire logic clock,
  input wire logic srst,
  input wire logic [`QPC_ADDR_W-1:0] addr,
  input wire logic [`QPC_DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [`QPC_DATA_W-1:0] rdata,
  input wire qpc_pkg::qpc_pins_s pins,
  input wire qpc_pkg::qpc_power_s power,
  output logic dir_out,
  output logic irq_pulse
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [`QPC_DATA_W-1:0] ctrl_reg;
  logic [`QPC_DATA_W-1:0] filt_reg;
  logic [`QPC_DATA_W-1:0] pos_reg;
  logic [`QPC_DATA_W-1:0] max_reg;
  logic irq_seen_reg;
  logic dir_reg;
  qpc_pkg::qpc_pins_s pins_reg;
  qpc_pkg::qpc_pins_s filt_out_reg;
  logic [`QPC_DIV_W-1:0] div_reg;
  logic [1:0] stable_reg [0:2];
  logic [2:0] cand_reg;

  qpc_pkg::qpc_mode_e mode;
  logic run;
  logic filt_tick;
  logic [2:0] raw_in;
  logic [2:0] filt_in;
  qpc_pkg::qpc_pins_s use_pins;
  logic a_edge;
  logic b_edge;
  logic count_pulse;
  logic enc_dir;
  logic timer_dir;
  logic up;
  logic index_match;
  logic index_event;
  logic is_index_mode;
  logic is_match_mode;
  logic err_event;
  logic wrap_event;
  logic timer_match;
  logic irq_next;

  function automatic logic wr_hit(input logic [`QPC_ADDR_W-1:0] a, input logic [`QPC_ADDR_W-1:0] off, input logic w);
    wr_hit = w && (a == off);
  endfunction : wr_hit

  assign mode = qpc_pkg::qpc_mode_e'(ctrl_reg[`QPC_CTRL_MODE_HI:`QPC_CTRL_MODE_LO]);
  // sleep always stops, idle stops only when asked to
  assign run = !power.sleep && !(power.idle && ctrl_reg[`QPC_CTRL_IDLE_STOP]);
  assign is_index_mode = (mode == qpc_pkg::QPC_MODE_X2_INDEX) || (mode == qpc_pkg::QPC_MODE_X4_INDEX);
  assign is_match_mode = (mode == qpc_pkg::QPC_MODE_X2_MATCH) || (mode == qpc_pkg::QPC_MODE_X4_MATCH);

  // ----------------------------------------------------------------
  // noise filters
  // ----------------------------------------------------------------
  // divide ratio is 2^field; tick whenever the divided bits roll over
  assign filt_tick = (div_reg & ((`QPC_DIV_W'(1) << filt_reg[`QPC_FILT_DIV_HI:`QPC_FILT_DIV_LO]) - `QPC_DIV_W'(1)))
                     == `QPC_DIV_W'(0);
  assign raw_in = {pins_reg.phase_a, pins_reg.phase_b, pins_reg.index};

  always_ff @(posedge clock)
  begin
    if (srst)
      div_reg <= '0;
    else
      div_reg <= div_reg + `QPC_DIV_W'(1);
  end

  // pins are sampled once so edges are seen against a registered copy
  always_ff @(posedge clock)
  begin
    if (srst)
      pins_reg <= '0;
    else
      pins_reg <= pins;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_filt
      always_ff @(posedge clock)
      begin
        if (srst)
        begin
          stable_reg[gi] <= 2'h0;
          cand_reg[gi] <= 1'b0;
          filt_in[gi] <= 1'b0;
        end
        else if (filt_tick)
        begin
          if (raw_in[gi] != cand_reg[gi])
          begin
            cand_reg[gi] <= raw_in[gi];
            stable_reg[gi] <= 2'h1;
          end
          else if (stable_reg[gi] != `QPC_FILT_STABLE)
            stable_reg[gi] <= stable_reg[gi] + 2'h1;
          else
            filt_in[gi] <= cand_reg[gi];
        end
      end
    end
  endgenerate

  // filter enable clears on reset, so raw pins are used until software enables it
  assign use_pins = filt_reg[`QPC_FILT_OUT_EN] ? qpc_pkg::qpc_pins_s'(filt_in) : pins_reg;

  always_ff @(posedge clock)
  begin
    if (srst)
      filt_out_reg <= '0;
    else
      filt_out_reg <= use_pins;
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign a_edge = use_pins.phase_a != filt_out_reg.phase_a;
  assign b_edge = use_pins.phase_b != filt_out_reg.phase_b;
  // a leading b: on an a edge the new a differs from b; on a b edge the new b equals a
  assign enc_dir = a_edge ? (use_pins.phase_a != use_pins.phase_b)
                          : (use_pins.phase_a == use_pins.phase_b);
  assign timer_dir = ctrl_reg[`QPC_CTRL_DIR_SRC] ? use_pins.phase_b : ctrl_reg[`QPC_CTRL_DIR];

  always_comb
  begin
    count_pulse = 1'b0;
    case (mode)
      qpc_pkg::QPC_MODE_X2_INDEX, qpc_pkg::QPC_MODE_X2_MATCH: count_pulse = a_edge;
      qpc_pkg::QPC_MODE_X4_INDEX, qpc_pkg::QPC_MODE_X4_MATCH: count_pulse = a_edge || b_edge;
      qpc_pkg::QPC_MODE_TIMER: count_pulse = use_pins.phase_a && !filt_out_reg.phase_a;
      default: count_pulse = 1'b0;
    endcase
  end

  // the step itself decides its direction; the stored value lags by one edge
  assign up = (mode == qpc_pkg::QPC_MODE_TIMER) ? timer_dir
              : ((run && mode[2] && (a_edge || b_edge)) ? enc_dir : dir_reg);

  always_comb
  begin
    index_match = 1'b0;
    if (mode == qpc_pkg::QPC_MODE_X4_INDEX)
      index_match = (use_pins.phase_b == filt_reg[`QPC_FILT_IMV_HI])
                    && (use_pins.phase_a == filt_reg[`QPC_FILT_IMV_LO]);
    else
      index_match = (filt_reg[`QPC_FILT_IMV_HI] ? use_pins.phase_b : use_pins.phase_a)
                    == filt_reg[`QPC_FILT_IMV_LO];
  end

  // qualified index: rising index with phases at the programmed state
  assign index_event = run && is_index_mode && use_pins.index && !filt_out_reg.index && index_match;

  // ----------------------------------------------------------------
  // position count
  // ----------------------------------------------------------------
  // the count is checked before the step: a step up from max or down from zero is the error
  assign err_event = run && is_index_mode && count_pulse
                     && (up ? (pos_reg == max_reg) : (pos_reg == `QPC_ZERO16));
  assign wrap_event = run && is_match_mode && count_pulse
                      && (up ? (pos_reg == max_reg) : (pos_reg == `QPC_ZERO16));
  assign timer_match = run && (mode == qpc_pkg::QPC_MODE_TIMER) && count_pulse
                       && (timer_dir ? (pos_reg == max_reg) : (pos_reg == `QPC_ZERO16));

  always_ff @(posedge clock)
  begin
    if (srst)
      dir_reg <= 1'b0;
    else if (run && (a_edge || b_edge) && mode[2])
      dir_reg <= enc_dir;
    else if (run && mode == qpc_pkg::QPC_MODE_TIMER)
      dir_reg <= timer_dir;
  end

  // mode changes never touch the count register
  always_ff @(posedge clock)
  begin
    if (srst)
      pos_reg <= `QPC_POS_RESET;
    else if (wr_hit(addr, `QPC_OFF_POS, wr_en))
      pos_reg <= wdata;
    else if (index_event && ctrl_reg[`QPC_CTRL_IDX_RST])
      pos_reg <= `QPC_ZERO16;
    else if (wrap_event || timer_match)
      pos_reg <= up ? `QPC_ZERO16 : max_reg;
    else if (run && count_pulse)
      pos_reg <= up ? pos_reg + `QPC_ONE16 : pos_reg - `QPC_ONE16;
  end

  // ----------------------------------------------------------------
  // control and status
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      ctrl_reg <= '0;
    else
    begin
      if (wr_hit(addr, `QPC_OFF_CTRL, wr_en))
        ctrl_reg <= wdata & `QPC_CTRL_WMASK;
      // set wins over a software clear in the same cycle
      if (err_event)
        ctrl_reg[`QPC_CTRL_ERR] <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      filt_reg <= '0;
    else if (wr_hit(addr, `QPC_OFF_FILT, wr_en))
      filt_reg <= wdata & `QPC_FILT_WMASK;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      max_reg <= `QPC_MAX_RESET;
    else if (wr_hit(addr, `QPC_OFF_MAX, wr_en))
      max_reg <= wdata;
  end

  // index interrupt fires whatever the reset enable; rollover in index modes stays silent
  assign irq_next = (err_event && !filt_reg[`QPC_FILT_COUNT_ERROR_IRQ_DISABLE])
                    || index_event
                    || wrap_event || timer_match;

  always_ff @(posedge clock)
  begin
    if (srst)
      irq_pulse <= 1'b0;
    else
      irq_pulse <= irq_next;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      irq_seen_reg <= 1'b0;
    else if (irq_next)
      irq_seen_reg <= 1'b1;
    else if (wr_hit(addr, `QPC_OFF_SYS, wr_en) && wdata[`QPC_SYS_IRQ])
      irq_seen_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      dir_out <= 1'b0;
    else
      dir_out <= up;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      rdata <= '0;
    else if (!rd_en)
      rdata <= '0;
    else
    begin
      case (addr)
        `QPC_OFF_CTRL:
        begin
          rdata <= ctrl_reg;
          rdata[`QPC_CTRL_DIR] <= up;
          rdata[`QPC_CTRL_INDEX] <= use_pins.index;
        end
        `QPC_OFF_FILT: rdata <= filt_reg;
        `QPC_OFF_POS: rdata <= pos_reg;
        `QPC_OFF_MAX: rdata <= max_reg;
        `QPC_OFF_SYS: rdata <= {15'h0000, irq_seen_reg};
        default: rdata <= '0;
      endcase
    end
  end

endmodule : qpc_counter
`default_nettype wire

// >>> pkg/qpc_regs.svh
// register offsets, field positions, reset values and timing constants of the quadrature position counter
// assumes a plain address/strobe register port with 16-bit data in the low bits
`ifndef QPC_REGS_SVH
`define QPC_REGS_SVH

`define QPC_ADDR_W 4
`define QPC_DATA_W 16
`define QPC_OFF_CTRL 4'h0
`define QPC_OFF_FILT 4'h2
`define QPC_OFF_POS 4'h4
`define QPC_OFF_MAX 4'h6
`define QPC_OFF_SYS 4'h8

// control register fields
`define QPC_CTRL_ERR 15
`define QPC_CTRL_IDLE_STOP 13
`define QPC_CTRL_INDEX 12
`define QPC_CTRL_DIR 11
`define QPC_CTRL_MODE_HI 10
`define QPC_CTRL_MODE_LO 8
`define QPC_CTRL_IDX_RST 2
`define QPC_CTRL_DIR_SRC 0
`define QPC_CTRL_WMASK 16'hAF05

// filter register fields
`define QPC_FILT_IMV_HI 10
`define QPC_FILT_IMV_LO 9
`define QPC_FILT_COUNT_ERROR_IRQ_DISABLE 8
`define QPC_FILT_OUT_EN 7
`define QPC_FILT_DIV_HI 6
`define QPC_FILT_DIV_LO 4
`define QPC_FILT_WMASK 16'h07F0

// system register fields: software-visible event stickies
`define QPC_SYS_IRQ 0

`define QPC_POS_RESET 16'h0000
`define QPC_MAX_RESET 16'hFFFF
`define QPC_ALL_ONES 16'hFFFF
`define QPC_ZERO16 16'h0000
`define QPC_ONE16 16'h0001

// stable samples a filter needs before its output follows the input
`define QPC_FILT_STABLE 2'h3
`define QPC_DIV_W 8

`endif

// >>> pkg/qpc_pkg.sv
// types of the quadrature position counter
// assumes qpc_regs.svh supplies the numeric constants
`default_nettype none
package qpc_pkg;

  typedef enum logic [2:0] {
    QPC_MODE_OFF = 3'b000,
    QPC_MODE_TIMER = 3'b001,
    QPC_MODE_RSV2 = 3'b010,
    QPC_MODE_RSV3 = 3'b011,
    QPC_MODE_X2_INDEX = 3'b100,
    QPC_MODE_X2_MATCH = 3'b101,
    QPC_MODE_X4_INDEX = 3'b110,
    QPC_MODE_X4_MATCH = 3'b111
  } qpc_mode_e;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic index;
  } qpc_pins_s;

  typedef struct packed {
    logic sleep;
    logic idle;
  } qpc_power_s;

endpackage : qpc_pkg
`default_nettype wire

// >>> tb/qpc_counter_properties.sv
// port checker for the quadrature position counter
// assumes it is bound to qpc_counter; one clock domain
`timescale 1ns/1ps
`default_nettype none
module qpc_counter_properties (
  input wire logic clock,
  input wire logic srst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rdata,
  input wire qpc_pkg::qpc_pins_s pins,
  input wire qpc_pkg::qpc_power_s power,
  input wire logic dir_out,
  input wire logic irq_pulse
);
  // ----
  // properties
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_rdata_quiet: assert property (!$past(rd_en) |-> rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (rd_en && !(addr inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h8}) |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_ctrl_reserved: assert property (rd_en && addr == 4'h0 |=> (rdata & 16'h40FA) == 16'h0000)
    else $error("control reserved bits set");
  a_dir_status: assert property ($past(rd_en) && $past(addr) == 4'h0 && $stable(dir_out) |-> rdata[11] == dir_out)
    else $error("direction status differs from pin");
  a_max_readback: assert property (wr_en && addr == 4'h6 ##1 rd_en && addr == 4'h6 |=> rdata == $past(wdata, 2))
    else $error("max count readback wrong");
  a_filt_readback: assert property (wr_en && addr == 4'h2 ##1 rd_en && addr == 4'h2 |=>
    rdata == ($past(wdata, 2) & 16'h07F0))
    else $error("filter control readback wrong");
  a_ctrl_readback: assert property (wr_en && addr == 4'h0 ##1 rd_en && addr == 4'h0 |=>
    (rdata & 16'h2705) == ($past(wdata, 2) & 16'h2705))
    else $error("control readback wrong");
  // an event already in flight may land in the first sleeping cycle
  a_sleep_quiet: assert property (power.sleep [*4] |-> !irq_pulse)
    else $error("event while asleep");
  c_irq: cover property (irq_pulse);
  c_dir_up: cover property ($rose(dir_out));
  c_err_read: cover property ($past(rd_en) && $past(addr) == 4'h0 && rdata[15]);
endmodule : qpc_counter_properties
`default_nettype wire

// >>> tb/qpc_encoder_model.sv
// encoder model: two phases in quadrature and a gated index
// assumes steps come no closer than four clocks apart
`timescale 1ns/1ps
`default_nettype none
module qpc_encoder_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic step,
  input wire logic fwd,
  input wire logic idx_req,
  output var qpc_pkg::qpc_pins_s pins
);
  logic [1:0] phase_reg;
  always_ff @(posedge clock)
    if (srst)
      phase_reg <= 2'h0;
    else if (step)
      phase_reg <= fwd ? phase_reg + 2'h1 : phase_reg - 2'h1;
  // index only shows with both phases low
  assign pins = '{phase_a: phase_reg[1] ^ phase_reg[0], phase_b: phase_reg[1], index: idx_req && phase_reg == 2'h0};
endmodule : qpc_encoder_model
`default_nettype wire

// >>> tb/test_qpc_counter.sv
// self-checking bench of the quadrature position counter
// assumes the encoder model drives the pins; register port per hand-over
`timescale 1ns/1ps
`default_nettype none
module test_qpc_counter;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rdata;
  qpc_pkg::qpc_pins_s pins;
  qpc_pkg::qpc_power_s power = 2'h0;
  logic dir_out, irq_pulse;
  logic step = 1'b0;
  logic fwd = 1'b1;
  logic idx_req = 1'b0;
  int failures = 0;
  int samples_checked = 0;
  always #50 clock = ~clock;
  qpc_counter u_qpc_counter (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .pins(pins), .power(power), .dir_out(dir_out), .irq_pulse(irq_pulse));
  qpc_encoder_model u_qpc_encoder_model (.clock(clock), .srst(srst), .step(step), .fwd(fwd), .idx_req(idx_req),
    .pins(pins));
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    if (wr_en)
      @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    @(posedge clock);
    chk(rdata, exp);
  endtask : rd
  task automatic mv(input logic f, input int n);
    repeat (n)
    begin
      step <= 1'b1;
      fwd <= f;
      @(posedge clock);
      step <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask : mv
  task automatic idx(input logic [15:0] exp);
    wr(4'h4, 16'h0005);
    idx_req <= 1'b1;
    repeat (4) @(posedge clock);
    idx_req <= 1'b0;
    repeat (3) @(posedge clock);
    rd(4'h4, exp);
  endtask : idx
  // ----
  // scenarios
  // ----
  task automatic s_reset;
    rd(4'h0, 16'h0000);
    rd(4'h2, 16'h0000);
    rd(4'h4, 16'h0000);
    rd(4'h6, 16'hFFFF);
    rd(4'hA, 16'h0000);
  endtask : s_reset
  task automatic s_decode;
    wr(4'h0, 16'h0600);
    mv(1'b1, 4);
    rd(4'h4, 16'h0004);
    chk({15'h0000, dir_out}, 16'h0001);
    mv(1'b0, 2);
    chk({15'h0000, dir_out}, 16'h0000);
    rd(4'h4, 16'h0002);
    wr(4'h4, 16'h0000);
    wr(4'h0, 16'h0400);
    mv(1'b1, 4);
    rd(4'h4, 16'h0002);
  endtask : s_decode
  task automatic s_error;
    wr(4'h6, 16'h0100);
    wr(4'h8, 16'h0001);
    wr(4'h0, 16'h0600);
    wr(4'h4, 16'h0000);
    mv(1'b0, 1);
    chk({15'h0000, irq_pulse}, 16'h0001);
    rd(4'h0, 16'h8600);
    rd(4'h8, 16'h0001);
    wr(4'h8, 16'h0001);
    mv(1'b1, 1);
    rd(4'h4, 16'h0000);
    rd(4'h8, 16'h0000);
    wr(4'h0, 16'h0600);
    rd(4'h0, 16'h0E00);
    wr(4'h2, 16'h0100);
    mv(1'b0, 1);
    chk({15'h0000, irq_pulse}, 16'h0000);
    rd(4'h0, 16'h8600);
    rd(4'h8, 16'h0000);
    wr(4'h2, 16'h0000);
    wr(4'h0, 16'h0700);
    wr(4'h4, 16'h0000);
    mv(1'b0, 1);
    rd(4'h0, 16'h0700);
    rd(4'h4, 16'h0100);
  endtask : s_error
  task automatic s_index;
    wr(4'h0, 16'h0604);
    idx(16'h0000);
    wr(4'h2, 16'h0600);
    rd(4'h2, 16'h0600);
    idx(16'h0005);
    wr(4'h0, 16'h0404);
    wr(4'h2, 16'h0400);
    idx(16'h0000);
    wr(4'h2, 16'h0000);
    wr(4'h0, 16'h0600);
    wr(4'h8, 16'h0001);
    idx(16'h0005);
    rd(4'h8, 16'h0001);
  endtask : s_index
  task automatic s_power;
    wr(4'h4, 16'h0000);
    power <= 2'h2;
    mv(1'b1, 4);
    rd(4'h4, 16'h0000);
    power <= 2'h1;
    mv(1'b1, 2);
    rd(4'h4, 16'h0002);
    wr(4'h0, 16'h2600);
    rd(4'h0, 16'h2E00);
    mv(1'b1, 4);
    rd(4'h4, 16'h0002);
    power <= 2'h0;
  endtask : s_power
  task automatic s_timer;
    wr(4'h0, 16'h0900);
    rd(4'h4, 16'h0002);
    wr(4'h6, 16'h0003);
    rd(4'h6, 16'h0003);
    mv(1'b1, 4);
    rd(4'h4, 16'h0003);
    wr(4'h8, 16'h0001);
    mv(1'b1, 4);
    rd(4'h4, 16'h0000);
    rd(4'h8, 16'h0001);
    wr(4'h0, 16'h0101);
    mv(1'b1, 4);
    rd(4'h4, 16'h0003);
  endtask : s_timer
  task automatic s_filter;
    wr(4'h0, 16'h0604);
    wr(4'h4, 16'h0000);
    wr(4'h2, 16'h0080);
    rd(4'h2, 16'h0080);
    mv(1'b1, 2);
    repeat (4) @(posedge clock);
    rd(4'h4, 16'h0002);
    // a one-cycle index spike must never reach the reset
    idx_req <= 1'b1;
    @(posedge clock);
    idx_req <= 1'b0;
    repeat (8) @(posedge clock);
    rd(4'h4, 16'h0002);
    idx(16'h0000);
  endtask : s_filter
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    s_reset();
    s_decode();
    s_error();
    s_index();
    s_power();
    s_timer();
    s_filter();
    tally_and_finish();
  end
  // a hang ends the run as a failure
  initial
  begin
    #1000000;
    failures++;
    tally_and_finish();
  end
endmodule : test_qpc_counter
bind qpc_counter qpc_counter_properties u_qpc_counter_properties (.clock(clock), .srst(srst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pins(pins), .power(power), .dir_out(dir_out),
  .irq_pulse(irq_pulse));
`default_nettype wire
